// File: core/msar_consts.vh
`ifndef MSAR_CONSTS_VH
`define MSAR_CONSTS_VH
// ********************************
// command codes and frame shape
// ********************************
`define MSAR_CMD_SUMMARY    8'hD0
`define MSAR_CMD_UNIT       8'hD1
`define MSAR_CMD_ALARM      8'hD2
`define MSAR_CNT_SUMMARY    8'h0B
`define MSAR_CNT_ALARM      8'h03
`define MSAR_PEC_IDX_SUMMARY 4'hC
`define MSAR_PEC_IDX_UNIT   4'h2
`define MSAR_PEC_IDX_ALARM  4'h4
`define MSAR_SUMMARY_BASE   4'h1
`define MSAR_ALARM_BASE     4'h1
`define MSAR_IDX_FIRST      4'h0
`define MSAR_IDX_STEP       4'h1
`define MSAR_FILL_BYTE      8'hFF
`define MSAR_BIT_LAST       3'h7
`define MSAR_BIT_STEP       3'h1
// ********************************
// pec
// ********************************
`define MSAR_CRC_POLY       8'h07
`define MSAR_CRC_INIT       8'h00
// ********************************
// status-2 / status-1 / alarm-3 fields
// ********************************
`define MSAR_S2_PEC_ERR     7
`define MSAR_S2_OC_MODE     6
`define MSAR_S2_INVALID     5
`define MSAR_S2_CAP_HL      4
`define MSAR_S2_ORTEST_FAIL 3
`define MSAR_S2_RANGE       1
`define MSAR_S2_REMOTE      0
`define MSAR_S1_OT_MODE     7
`define MSAR_S1_ORTEST_OK   6
`define MSAR_S1_INT_FAULT   5
`define MSAR_S1_SHUTDOWN    4
`define MSAR_S1_EXT_FAULT   2
`define MSAR_S1_LAMP        1
`define MSAR_S1_OUT_ON      0
`define MSAR_A3_INTERLOCK   7
`define MSAR_A3_FUSE        6
`define MSAR_A3_PFC_LINK    5
`define MSAR_A3_DC_LINK     4
`define MSAR_A3_AC_LINK     3
`define MSAR_A3_ORING       0
`define MSAR_OC_MODE_RST    1'b1
`define MSAR_OT_MODE_RST    1'b1
`define MSAR_BYTE_ZERO      8'h00
`define MSAR_WORD_ZERO      16'h0000
`endif

// File: core/msar_crc8.v
`timescale 1ns/1ps
`default_nettype none
`include "msar_consts.vh"
module msar_crc8 (
	input  wire       ref_clk,
	input  wire       rst,
	input  wire       clear,
	input  wire       byteStrobe,
	input  wire [7:0] byteData,
	output reg  [7:0] crc_q
);
	// ********************************
	// smbus crc-8, one byte per strobe
	// ********************************
	function [7:0] crcNext;
		input [7:0] c;
		input [7:0] d;
		integer     i;
		reg   [7:0] x;
		begin
			x = c ^ d;
			for (i = 0; i < 8; i = i + 1) begin
				x = x[7] ? ({x[6:0], 1'b0} ^ `MSAR_CRC_POLY) : {x[6:0], 1'b0};
			end
			crcNext = x;
		end
	endfunction

	always @(posedge ref_clk) begin
		if (rst || clear) begin
			crc_q <= `MSAR_CRC_INIT;
		end else if (byteStrobe) begin
			crc_q <= crcNext(crc_q, byteData);
		end
	end
endmodule // msar_crc8
`default_nettype wire

// File: core/msar_readback.v
`timescale 1ns/1ps
`default_nettype none
`include "msar_consts.vh"
// Overview of operation
// - replies over two bytes use block read
// - command write, repeated start, then device sends
// - block data opens with byte count, closes with PEC
// - analog words go low byte first
// - status, alarms readable together or in batches
// - 0xD0 returns count eleven, status, alarms, analogs
// - summary temperature nearest its shutdown limit
// - 0xD1 returns status-2 then status-1 with PEC
// - status-2 bit layout
// - status-1 bit layout
// - 0xD2 returns alarm-3 first, alarm-1 last
// - alarm-3 bit layout, resets to zero; only the or'ing bit is reset, the other bits follow their inputs
// - or'ing fault from host or internal test
// - destructive or'ing fault forces shutdown
// - not ready data reads as all ones
module msar_readback #(
	parameter [6:0] DEV_ADDR = 7'h58
) (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        scl,
	input  wire        sdaIn,
	output reg         sdaOut_q,
	output reg         sdaOeN_q,
	input  wire        pecErrorIn,
	input  wire        overcurrentModeIn,
	input  wire        powerCapHighLineIn,
	input  wire        valueRangeErrorIn,
	input  wire        remoteOnIn,
	input  wire        overtempModeIn,
	input  wire        internalFaultIn,
	input  wire        shutdownIn,
	input  wire        externalFaultIn,
	input  wire        lampTestActive,
	input  wire        outputOnIn,
	input  wire        interlockOpen,
	input  wire        fuseFail,
	input  wire        pfcLinkFault,
	input  wire        dcLinkFault,
	input  wire        acMonLinkFault,
	input  wire        hostOringTestDone,
	input  wire        hostOringTestFail,
	input  wire        internalOringFail,
	input  wire        oringDestructive,
	input  wire [7:0]  alarm2In,
	input  wire [7:0]  alarm1In,
	input  wire [15:0] voltIn,
	input  wire [15:0] currIn,
	input  wire [15:0] tempPrimary,
	input  wire [15:0] tempPrimaryLimit,
	input  wire [15:0] tempSecondary,
	input  wire [15:0] tempSecondaryLimit,
	input  wire        dataReady,
	output reg         shutdownReq_q
);
	localparam [2:0] ST_IDLE = 3'd0, ST_ADDR = 3'd1, ST_ACK = 3'd2, ST_CMD = 3'd3;
	localparam [2:0] ST_WAIT = 3'd4, ST_TX = 3'd5, ST_RACK = 3'd6, ST_TXNEXT = 3'd7;

	// ********************************
	// pin synchronisers
	// ********************************
	reg sclS1_q, sclS2_q, sclS3_q, sdaS1_q, sdaS2_q, sdaS3_q;
	always @(posedge ref_clk) begin
		if (rst) begin
			{sclS1_q, sclS2_q, sclS3_q} <= 3'h7;
			{sdaS1_q, sdaS2_q, sdaS3_q} <= 3'h7;
		end else begin
			{sclS1_q, sclS2_q, sclS3_q} <= {scl, sclS1_q, sclS2_q};
			{sdaS1_q, sdaS2_q, sdaS3_q} <= {sdaIn, sdaS1_q, sdaS2_q};
		end
	end
	wire sclRise   = sclS2_q & ~sclS3_q;
	wire sclFall   = ~sclS2_q & sclS3_q;
	// only scl-high sda moves count; our own sda changes happen with scl low
	wire startSeen = sclS2_q & sclS3_q & sdaS3_q & ~sdaS2_q;
	wire stopSeen  = sclS2_q & sclS3_q & ~sdaS3_q & sdaS2_q;

	// ********************************
	// status and alarm sources
	// ********************************
	reg        ocMode_q, otMode_q, orTestFail_q, orTestOk_q, oringFault_q, invalid_q;
	reg [15:0] tempSel_q;
	wire       oringEvent = (hostOringTestDone & hostOringTestFail) | internalOringFail;

	function [15:0] margin;
		input [15:0] t;
		input [15:0] lim;
		begin
			margin = (lim > t) ? (lim - t) : `MSAR_WORD_ZERO;
		end
	endfunction

	always @(posedge ref_clk) begin
		if (rst) begin
			ocMode_q      <= `MSAR_OC_MODE_RST;
			otMode_q      <= `MSAR_OT_MODE_RST;
			orTestFail_q  <= 1'b0;
			orTestOk_q    <= 1'b0;
			oringFault_q  <= 1'b0;
			shutdownReq_q <= 1'b0;
			tempSel_q     <= `MSAR_WORD_ZERO;
		end else begin
			ocMode_q <= overcurrentModeIn;
			otMode_q <= overtempModeIn;
			if (hostOringTestDone) begin
				orTestFail_q <= hostOringTestFail;
				orTestOk_q   <= ~hostOringTestFail;
			end
			// fault sticks until a passing host test; a new failure wins
			if (oringEvent)
				oringFault_q <= 1'b1;
			else if (hostOringTestDone)
				oringFault_q <= 1'b0;
			// power capacity is the host's call; only destructive faults shut down
			if (oringEvent & oringDestructive)
				shutdownReq_q <= 1'b1;
			tempSel_q <= (margin(tempPrimary, tempPrimaryLimit) <= margin(tempSecondary, tempSecondaryLimit)) ?
				tempPrimary : tempSecondary;
		end
	end

	reg [7:0] status2, status1, alarm3;
	always @* begin
		status2 = `MSAR_BYTE_ZERO;
		status1 = `MSAR_BYTE_ZERO;
		alarm3  = `MSAR_BYTE_ZERO;
		status2[`MSAR_S2_PEC_ERR]     = pecErrorIn;
		status2[`MSAR_S2_OC_MODE]     = ocMode_q;
		status2[`MSAR_S2_INVALID]     = invalid_q;
		status2[`MSAR_S2_CAP_HL]      = powerCapHighLineIn;
		status2[`MSAR_S2_ORTEST_FAIL] = orTestFail_q;
		status2[`MSAR_S2_RANGE]       = valueRangeErrorIn;
		status2[`MSAR_S2_REMOTE]      = remoteOnIn;
		status1[`MSAR_S1_OT_MODE]     = otMode_q;
		status1[`MSAR_S1_ORTEST_OK]   = orTestOk_q;
		status1[`MSAR_S1_INT_FAULT]   = internalFaultIn;
		status1[`MSAR_S1_SHUTDOWN]    = shutdownIn | shutdownReq_q;
		status1[`MSAR_S1_EXT_FAULT]   = externalFaultIn;
		status1[`MSAR_S1_LAMP]        = lampTestActive;
		status1[`MSAR_S1_OUT_ON]      = outputOnIn;
		alarm3[`MSAR_A3_INTERLOCK]    = interlockOpen;
		alarm3[`MSAR_A3_FUSE]         = fuseFail;
		alarm3[`MSAR_A3_PFC_LINK]     = pfcLinkFault;
		alarm3[`MSAR_A3_DC_LINK]      = dcLinkFault;
		alarm3[`MSAR_A3_AC_LINK]      = acMonLinkFault;
		alarm3[`MSAR_A3_ORING]        = oringFault_q;
	end

	// ********************************
	// reply byte selection
	// ********************************
	function [7:0] snapByte;
		input [87:0] snap;
		input [3:0]  k;
		reg   [87:0] sh;
		begin
			sh       = snap >> {k, 3'b000};
			snapByte = sh[7:0];
		end
	endfunction

	function [7:0] respByte;
		input [7:0]  cmd;
		input [3:0]  idx;
		input [87:0] snap;
		input        ok;
		input [7:0]  crc;
		reg   [3:0]  kSum, kAlm;
		reg   [7:0]  dSum, dUnit, dAlm;
		begin
			kSum  = idx - `MSAR_SUMMARY_BASE;
			kAlm  = idx + `MSAR_ALARM_BASE;
			// stale data is worse than an obvious all-ones reply
			dSum  = ok ? snapByte(snap, kSum) : `MSAR_FILL_BYTE;
			dUnit = ok ? snapByte(snap, idx) : `MSAR_FILL_BYTE;
			dAlm  = ok ? snapByte(snap, kAlm) : `MSAR_FILL_BYTE;
			case (cmd)
				`MSAR_CMD_SUMMARY: begin
					if (idx == `MSAR_IDX_FIRST)
						respByte = `MSAR_CNT_SUMMARY;
					else if (idx < `MSAR_PEC_IDX_SUMMARY)
						respByte = dSum;
					else if (idx == `MSAR_PEC_IDX_SUMMARY)
						respByte = crc;
					else
						respByte = `MSAR_FILL_BYTE;
				end
				`MSAR_CMD_UNIT: begin
					if (idx < `MSAR_PEC_IDX_UNIT)
						respByte = dUnit;
					else if (idx == `MSAR_PEC_IDX_UNIT)
						respByte = crc;
					else
						respByte = `MSAR_FILL_BYTE;
				end
				`MSAR_CMD_ALARM: begin
					if (idx == `MSAR_IDX_FIRST)
						respByte = `MSAR_CNT_ALARM;
					else if (idx < `MSAR_PEC_IDX_ALARM)
						respByte = dAlm;
					else if (idx == `MSAR_PEC_IDX_ALARM)
						respByte = crc;
					else
						respByte = `MSAR_FILL_BYTE;
				end
				default: respByte = `MSAR_FILL_BYTE;
			endcase
		end
	endfunction

	// ********************************
	// smbus target
	// ********************************
	reg [2:0]  state_q, bitCnt_q;
	reg [7:0]  shift_q, txShift_q, cmd_q, crcByte_q;
	reg [3:0]  idx_q;
	reg [87:0] snap_q;
	reg        ackPhase_q, rdDir_q, cmdDone_q, snapOk_q, crcStrobe_q;
	wire [7:0] crc;
	wire [7:0] rxByte   = {shift_q[6:0], sdaS2_q};
	wire [7:0] nextByte = respByte(cmd_q, idx_q, snap_q, snapOk_q, crc);
	wire       busEdge  = startSeen | stopSeen;
	wire       rxLast   = sclRise & (bitCnt_q == `MSAR_BIT_LAST);
	wire       knownCmd = (rxByte == `MSAR_CMD_SUMMARY) | (rxByte == `MSAR_CMD_UNIT) | (rxByte == `MSAR_CMD_ALARM);
	wire       setInv   = ~busEdge & (state_q == ST_CMD) & rxLast & ~knownCmd;
	wire       clrInv   = ~busEdge & (state_q == ST_RACK) & sclRise & sdaS2_q & (cmd_q != `MSAR_CMD_ALARM);

	always @(posedge ref_clk) begin
		if (rst)
			invalid_q <= 1'b0;
		else if (setInv)
			invalid_q <= 1'b1;
		else if (clrInv)
			invalid_q <= 1'b0;
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			state_q     <= ST_IDLE;
			bitCnt_q    <= 3'h0;
			shift_q     <= `MSAR_BYTE_ZERO;
			txShift_q   <= `MSAR_FILL_BYTE;
			cmd_q       <= `MSAR_BYTE_ZERO;
			crcByte_q   <= `MSAR_BYTE_ZERO;
			idx_q       <= `MSAR_IDX_FIRST;
			snap_q      <= 88'h0;
			ackPhase_q  <= 1'b0;
			rdDir_q     <= 1'b0;
			cmdDone_q   <= 1'b0;
			snapOk_q    <= 1'b0;
			crcStrobe_q <= 1'b0;
			sdaOut_q    <= 1'b0;
			sdaOeN_q    <= 1'b1;
		end else begin
			crcStrobe_q <= 1'b0;
			if (stopSeen) begin
				state_q   <= ST_IDLE;
				cmdDone_q <= 1'b0;
				sdaOeN_q  <= 1'b1;
			end else if (startSeen) begin
				state_q    <= ST_ADDR;
				bitCnt_q   <= 3'h0;
				ackPhase_q <= 1'b0;
				sdaOeN_q   <= 1'b1;
			end else begin
				case (state_q)
					ST_ADDR, ST_CMD: begin
						if (sclRise) begin
							shift_q  <= rxByte;
							bitCnt_q <= bitCnt_q + `MSAR_BIT_STEP;
						end
						if (rxLast) begin
							crcByte_q   <= rxByte;
							crcStrobe_q <= 1'b1;
							if (state_q == ST_CMD) begin
								cmd_q     <= rxByte;
								cmdDone_q <= 1'b1;
								state_q   <= ST_ACK;
							end else if ((rxByte[7:1] == DEV_ADDR) && (!rxByte[0] || cmdDone_q)) begin
								rdDir_q <= rxByte[0];
								state_q <= ST_ACK;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					ST_ACK: begin
						if (sclFall && !ackPhase_q) begin
							sdaOeN_q   <= 1'b0;
							ackPhase_q <= 1'b1;
							// freeze the frame so multi-byte words stay coherent
							snap_q   <= {tempSel_q, currIn, voltIn, alarm1In, alarm2In, alarm3, status1, status2};
							snapOk_q <= dataReady;
							idx_q    <= `MSAR_IDX_FIRST;
						end else if (sclFall) begin
							ackPhase_q <= 1'b0;
							bitCnt_q   <= 3'h0;
							if (rdDir_q) begin
								txShift_q   <= nextByte;
								sdaOeN_q    <= nextByte[7];
								crcByte_q   <= nextByte;
								crcStrobe_q <= 1'b1;
								idx_q       <= idx_q + `MSAR_IDX_STEP;
								state_q     <= ST_TX;
							end else begin
								sdaOeN_q <= 1'b1;
								state_q  <= (cmd_q == rxByte && cmdDone_q && bitCnt_q == 3'h0) ? ST_WAIT : ST_CMD;
							end
						end
					end
					ST_TX: begin
						if (sclFall) begin
							if (bitCnt_q == `MSAR_BIT_LAST) begin
								sdaOeN_q <= 1'b1;
								state_q  <= ST_RACK;
							end else begin
								txShift_q <= {txShift_q[6:0], 1'b1};
								sdaOeN_q  <= txShift_q[6];
								bitCnt_q  <= bitCnt_q + `MSAR_BIT_STEP;
							end
						end
					end
					ST_RACK: begin
						if (sclRise)
							state_q <= sdaS2_q ? ST_IDLE : ST_TXNEXT;
					end
					ST_TXNEXT: begin
						if (sclFall) begin
							txShift_q   <= nextByte;
							sdaOeN_q    <= nextByte[7];
							crcByte_q   <= nextByte;
							crcStrobe_q <= 1'b1;
							idx_q       <= idx_q + `MSAR_IDX_STEP;
							bitCnt_q    <= 3'h0;
							state_q     <= ST_TX;
						end
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	msar_crc8 uCrc (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.clear      (stopSeen),
		.byteStrobe (crcStrobe_q),
		.byteData   (crcByte_q),
		.crc_q      (crc)
	);
endmodule // msar_readback
`default_nettype wire

// File: core/msar_readback_notes_unused.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: dv/msar_host.sv
`timescale 1ns/1ps
`default_nettype none
module msar_host (
	output var logic       sclOut,
	output var logic       sdaLow,
	input  wire logic      sdaWire,
	output var logic [7:0] rxByte,
	output var logic       rxStrobe
);
	// ****
	// smbus master, 160 ns clock
	// ****
	initial begin
		{sclOut, sdaLow, rxStrobe, rxByte} = 11'h400;
	end
	task automatic bitOut(input logic b);
		sdaLow = !b;
		#40 sclOut = 1;
		#80 sclOut = 0;
		#40;
	endtask
	// sample late in the high phase, clear of the target's change after the fall
	task automatic bitIn(output logic b);
		sdaLow = 0;
		#40 sclOut = 1;
		#70 b = sdaWire;
		#10 sclOut = 0;
		#40;
	endtask
	task automatic start();
		sdaLow = 0;
		#40 sclOut = 1;
		#80 sdaLow = 1;
		#80 sclOut = 0;
		#40;
	endtask
	task automatic stop();
		sdaLow = 1;
		#40 sclOut = 1;
		#80 sdaLow = 0;
		#80;
	endtask
	task automatic wrByte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) bitOut(d[i]);
		bitIn(b);
		ack = !b;
	endtask
	task automatic rdByte(input logic last);
		logic b;
		logic [7:0] d;
		for (int i = 0; i < 8; i++) begin
			bitIn(b);
			d = {d[6:0], b};
		end
		rxByte = d;
		rxStrobe = 1;
		bitOut(last);
		rxStrobe = 0;
	endtask
endmodule // msar_host
`default_nettype wire

// File: dv/msar_readback_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module msar_readback_asserts (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sdaOut_q,
	input wire logic sdaOeN_q,
	input wire logic hostOringTestDone,
	input wire logic hostOringTestFail,
	input wire logic internalOringFail,
	input wire logic oringDestructive,
	input wire logic shutdownReq_q
);
	// ****
	// bus timing and or'ing shutdown
	// ****
	wire logic destEvt = oringDestructive & (internalOringFail | hostOringTestDone & hostOringTestFail);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_sda_open: assert property (sdaOut_q == 1'b0) else $error("sda data not low");
	chk_sda_sclLow: assert property ($changed(sdaOeN_q) |-> !scl) else $error("sda moved, scl high");
	chk_change_lag: assert property ($changed(sdaOeN_q) |-> !$past(scl) && !$past(scl, 2))
		else $error("sda moved too early");
	chk_fall_hold: assert property ($fell(scl) |-> $stable(sdaOeN_q)) else $error("no hold");
	chk_idle_release: assert property (scl [*6] |-> sdaOeN_q) else $error("sda held");
	chk_shut_hold: assert property (shutdownReq_q |=> shutdownReq_q) else $error("shut lost");
	chk_shut_cause: assert property ($rose(shutdownReq_q) |-> $past(destEvt) || $past(destEvt, 2))
		else $error("shut no cause");
	chk_shut_raise: assert property (destEvt |-> ##[1:2] shutdownReq_q) else $error("no shut");
endmodule // msar_readback_asserts
bind msar_readback msar_readback_asserts chk (.ref_clk(ref_clk), .rst(rst), .scl(scl), .sdaOut_q(sdaOut_q),
	.sdaOeN_q(sdaOeN_q), .hostOringTestDone(hostOringTestDone), .hostOringTestFail(hostOringTestFail),
	.internalOringFail(internalOringFail), .oringDestructive(oringDestructive), .shutdownReq_q(shutdownReq_q));
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ****
	// bench
	// ****
	localparam logic [6:0] ADDR = 7'h58;
	logic       ref_clk, rst, hDone, hFail, iFail, scl, hostLow, rxStrobe, sdaOeN, shut;
	logic       inv, of, ok, flt, sh;
	logic [7:0] rxByte;
	logic [33:0] st;
	logic [95:0] an;
	logic [8:0] q[$];
	logic [7:0] cmds[4] = '{8'hD0, 8'hD1, 8'hD2, 8'hD5};
	int         seed, failures, total_checks, nExp;
	wire logic  sdaWire = ~hostLow & (sdaOeN !== 1'b0);
	initial begin
		ref_clk = 0;
		forever #10 ref_clk = ~ref_clk;
	end
	msar_host host (.sclOut(scl), .sdaLow(hostLow), .sdaWire(sdaWire), .rxByte(rxByte), .rxStrobe(rxStrobe));
	msar_readback DUT (.ref_clk(ref_clk), .rst(rst), .scl(scl), .sdaIn(sdaWire), .sdaOut_q(), .sdaOeN_q(sdaOeN),
		.pecErrorIn(st[0]), .overcurrentModeIn(st[1]), .powerCapHighLineIn(st[2]), .valueRangeErrorIn(st[3]),
		.remoteOnIn(st[4]), .overtempModeIn(st[5]), .internalFaultIn(st[6]), .shutdownIn(st[7]),
		.externalFaultIn(st[8]), .lampTestActive(st[9]), .outputOnIn(st[10]), .acMonLinkFault(st[11]),
		.dcLinkFault(st[12]), .pfcLinkFault(st[13]), .fuseFail(st[14]), .interlockOpen(st[15]),
		.hostOringTestDone(hDone), .hostOringTestFail(hFail), .internalOringFail(iFail),
		.oringDestructive(st[32]), .alarm2In(st[23:16]), .alarm1In(st[31:24]), .voltIn(an[15:0]),
		.currIn(an[31:16]), .tempPrimary(an[47:32]), .tempPrimaryLimit(an[63:48]), .tempSecondary(an[79:64]),
		.tempSecondaryLimit(an[95:80]), .dataReady(st[33]), .shutdownReq_q(shut));
	function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] x;
		x = c ^ d;
		repeat (8) x = x[7] ? (x << 1) ^ 8'h07 : x << 1;
		return x;
	endfunction
	task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic plan(input logic [7:0] c);
		logic [7:0]  v[$];
		logic [7:0]  s2, s1, a3, cr;
		logic [15:0] dp, ds, tw;
		s2 = {st[0], st[1], inv, st[2], of, 1'b0, st[3], st[4]};
		s1 = {st[5], ok, st[6], st[7] | sh, 1'b0, st[8], st[9], st[10]};
		a3 = {st[15:11], 2'b00, flt};
		dp = an[63:48] > an[47:32] ? an[63:48] - an[47:32] : 16'h0000;
		ds = an[95:80] > an[79:64] ? an[95:80] - an[79:64] : 16'h0000;
		tw = ds < dp ? an[79:64] : an[47:32];
		case (c)
			8'hD0: v = {8'h0B, s2, s1, a3, st[23:16], st[31:24], an[7:0], an[15:8], an[23:16], an[31:24],
				tw[7:0], tw[15:8]};
			8'hD1: v = {s2, s1};
			8'hD2: v = {8'h03, a3, st[23:16], st[31:24]};
			default: begin
				v = {8'hFF, 8'hFF};
				inv = 1;
			end
		endcase
		if (!st[33]) foreach (v[i]) v[i] = 8'hFF;
		cr = crc(crc(crc(8'h00, {ADDR, 1'b0}), c), {ADDR, 1'b1});
		foreach (v[i]) begin
			q.push_back({1'b0, v[i]});
			cr = crc(cr, v[i]);
		end
		// pec after not-ready fill bytes is left open, so it is not compared
		q.push_back({!st[33], c inside {8'hD0, 8'hD1, 8'hD2} ? cr : 8'hFF});
		// the invalid bit drops on any closing nack except an alarm read
		if (c != 8'hD2) inv = 0;
		nExp = v.size() + 1;
	endtask
	task automatic xfer(input logic [7:0] c);
		logic a;
		host.start();
		host.wrByte({ADDR, 1'b0}, a);
		check("ackW", 8'h01, {7'h00, a});
		host.wrByte(c, a);
		check("ackC", 8'h01, {7'h00, a});
		host.start();
		host.wrByte({ADDR, 1'b1}, a);
		check("ackR", 8'h01, {7'h00, a});
		for (int i = 0; i < nExp; i++) host.rdByte(i == nExp - 1);
		host.stop();
	endtask
	task automatic refuse(input logic [7:0] b, input logic pre);
		logic a;
		if (pre) begin
			host.start();
			host.wrByte({ADDR, 1'b0}, a);
			host.wrByte(8'hD1, a);
			host.stop();
		end
		host.start();
		host.wrByte(b, a);
		check("nack", 8'h00, {7'h00, a});
		host.stop();
	endtask
	task automatic pulse(input logic d, input logic f, input logic i);
		@(posedge ref_clk) #1 {hDone, hFail, iFail} = {d, f, i};
		@(posedge ref_clk) #1 {hDone, hFail, iFail} = 3'b000;
		if (i | d & f) begin
			flt = 1;
			sh = sh | st[32];
		end else if (d) flt = 0;
		if (d) {of, ok} = {f, !f};
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin : mon
		logic [8:0] e;
		forever begin
			@(posedge rxStrobe);
			if (q.size() == 0) check("extra", 8'h00, 8'hFF);
			else begin
				e = q.pop_front();
				if (!e[8]) check("rx", e[7:0], rxByte);
			end
		end
	end
	initial begin
		#1_500_000 failures++;
		end_of_test();
	end
	initial begin
		seed = 73130;
		{rst, hDone, hFail, iFail, inv, of, ok, flt, sh} = 9'h100;
		st = {2'b10, 32'h0000_0000};
		an = '0;
		repeat (8) @(posedge ref_clk);
		#1 rst = 0;
		repeat (4) @(posedge ref_clk);
		repeat (3) foreach (cmds[k]) begin
			@(posedge ref_clk) #1 st = {2'b10, $random(seed)};
			an = {$random(seed), $random(seed), $random(seed)};
			plan(cmds[k]);
			xfer(cmds[k]);
		end
		@(posedge ref_clk) #1 st[33] = 0;
		plan(8'hD1);
		xfer(8'hD1);
		@(posedge ref_clk) #1 st[33] = 1;
		pulse(1, 1, 0);
		plan(8'hD0);
		xfer(8'hD0);
		check("shut", 8'h00, {7'h00, shut});
		pulse(1, 0, 0);
		plan(8'hD2);
		xfer(8'hD2);
		@(posedge ref_clk) #1 st[32] = 1;
		pulse(0, 0, 1);
		plan(8'hD0);
		xfer(8'hD0);
		check("shut", 8'h01, {7'h00, shut});
		refuse({ADDR, 1'b1}, 0);
		refuse({ADDR ^ 7'h01, 1'b0}, 0);
		refuse({ADDR, 1'b1}, 1);
		repeat (10) @(posedge ref_clk);
		if (q.size() != 0) failures++;
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
